// file: hw/tnco_regs.svh
// Purpose: register offsets, fields and timing counts of the timing oscillator block
// Assumes: control words addressed by word index on the host port
// Notes:   definitions only
`ifndef TNCO_REGS_SVH
`define TNCO_REGS_SVH
// ==========================================================================
// offsets
`define OFS_OSC_CONTROL      8'h0B
`define OFS_CENTER_FREQ      8'h0C
`define OFS_PHASE_OFFSET     8'h0D
`define OFS_FREQ_STROBE      8'h0E
`define OFS_PHASE_STROBE     8'h0F
`define OFS_ERROR_DIVIDERS   8'h12
`define OFS_ERROR_READ       8'h13
`define OFS_OFFSET_FREQ      8'h14
// ==========================================================================
// control word fields
`define CTL_SYNC_EN_BIT      5
`define CTL_OFS_BITS_LSB     3
`define CTL_OFS_EN_BIT       2
`define CTL_CLEAR_BIT        1
`define CTL_LOAD_ON_UPD_BIT  0
`define DIV_NCO_LSB          16
`define DIV_REF_LSB          0
`define DIV_WIDTH            12
// ==========================================================================
// reset values
`define RST_WORD             32'h0000_0000
// ==========================================================================
// resampler clocks per input sample and processing clock limit
`define CYC_BYPASS           6'h00
`define CYC_POLY             6'h06
`define CYC_POLY_HB1         6'h0D
`define CYC_POLY_HB2         6'h17
`define CYC_HB1              6'h07
`define CYC_HB2              6'h11
`define PROC_CLK_MAX_MHZ     55
`endif

// file: hw/tnco_pkg.sv
// Purpose: shared types of the timing oscillator block
// Assumes: nothing
// Notes:   constants live in tnco_regs.svh
package tnco_pkg;
    // ======================================================================
    // host write bundle
    typedef struct packed {
        logic        wr;
        logic [7:0]  addr;
        logic [31:0] data;
    } host_wr_type;
    // strobe plus phase towards the resampler
    typedef struct packed {
        logic        strobe;
        logic [31:0] phase;
    } sample_tick_type;
    typedef enum logic [5:0] {
        RS_BYPASS   = 6'b000001,
        RS_POLY     = 6'b000010,
        RS_POLY_HB1 = 6'b000100,
        RS_POLY_HB2 = 6'b001000,
        RS_HB1      = 6'b010000,
        RS_HB2      = 6'b100000
    } rs_mode_type;
endpackage

// file: hw/pin_sync.sv
// Purpose: three flop synchroniser with agreement on the last two stages
// Assumes: asynchronous level input
// Notes:   first stage only feeds the second
`timescale 1ns/1ps
module pin_sync (
    input  wire logic clk,      // processing clock
    input  wire logic sys_rst,  // sync reset
    input  wire logic pin,      // raw pin
    output logic      level     // filtered level
);
    logic s1_r, s2_r, s3_r;
    // ======================================================================
    // shift, accept only when stages two and three agree
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s1_r  <= 1'b0;
            s2_r  <= 1'b0;
            s3_r  <= 1'b0;
            level <= 1'b0;
        end else begin
            s1_r <= pin;
            s2_r <= s1_r;
            s3_r <= s2_r;
            if (s2_r == s3_r) level <= s3_r;
        end
    end
endmodule

// file: hw/divide_counter.sv
// Purpose: preloaded down counter with terminal count reload
// Assumes: advance is a one cycle pulse
// Notes:   reload happens on the advance that finds the count already at zero
`timescale 1ns/1ps
module divide_counter #(
    parameter int W = 12
) (
    input  wire logic         clk,      // processing clock
    input  wire logic         sys_rst,  // sync reset
    input  wire logic         advance,  // count pulse
    input  wire logic [W-1:0] preload,  // reload value
    output logic      [W-1:0] count,    // present count
    output logic              wrap      // pulse on reload
);
    wire at_zero = (count == '0);
    // ======================================================================
    // count down, reload at terminal count
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            count <= '0;
            wrap  <= 1'b0;
        end else begin
            wrap <= advance & at_zero;
            if (advance) count <= at_zero ? preload : count - 1'b1;
        end
    end
endmodule

// file: hw/timing_nco.sv
// Purpose: timing oscillator, sample strobe source and timing error detector
// Assumes: host writes word index plus data, one cycle write pulse
// Notes:   processing clock limited to 55 MHz in the real part
//
// Function
// R1 - oscillator drives sample strobe and phase into the resampler
// R2 - oscillator is a bare phase accumulator, no sine/cosine stage
// R3 - control bit 5 enables sync of the oscillator from external pin
// R4 - control bits 3-4 set width of serially loaded offset frequency
// R5 - control bit 2 adds offset frequency to centre frequency
// R6 - control bit 1 clears the phase accumulator
// R7 - control bit 0 loads the accumulator on update strobes
// R8 - centre frequency word is per clock accumulator increment
// R9 - eight bit phase offset is added to the oscillator phase
// R10 - writes to strobe words move pending values into active registers
// R11 - timing error compares carry-out counter with reference counter
// R12 - carry-out counter preload sits in divider bits 16-27
// R13 - reference counter preload sits in divider bits 0-11
// R14 - 16-bit timing error on serial output and host readable
// R15 - resampler needs 0,6,13,23,7,17 clocks per input by mode
// R16 - max input rate is 55 MHz divided by mode clocks
// R17 - each halfband doubles the rate, both give four outputs
// R18 - with polyphase active, oscillator strobes pace the output
// R19 - external loop filter feeds correction into offset frequency
// R20 - counters reload at terminal count, reference reload samples error
`timescale 1ns/1ps
`include "tnco_regs.svh"
module timing_nco #(
    parameter int DW = `DIV_WIDTH
) (
    input  wire logic                    clk,                // processing clock
    input  wire logic                    sys_rst,            // sync reset, high
    input  wire tnco_pkg::host_wr_type   host_wr,            // host write
    input  wire logic                    host_rd,            // host read pulse
    input  wire logic [7:0]              host_rd_addr,       // read index
    input  wire logic                    offset_ser_clk,     // serial offset strobe
    input  wire logic                    offset_ser_data,    // serial offset bit
    input  wire logic                    sync_in,            // external sync pin
    input  wire logic                    reference_clock_in, // reference pin
    input  wire tnco_pkg::rs_mode_type   rs_mode,            // resampler mode
    output tnco_pkg::sample_tick_type    tick,               // strobe and phase
    output logic [7:0]                   phase_out,          // offset phase
    output logic                         carry_out,          // oscillator wrap
    output logic [5:0]                   rs_cycles,          // clocks per input
    output logic [2:0]                   interp_factor,      // output per input
    output logic                         poly_paced,         // strobe pacing on
    output logic [31:0]                  host_rd_data,       // read data
    output logic                         timing_error_ser,   // serial error bit
    output logic                         timing_error_frame  // serial word start
);
    // ======================================================================
    // registers
    logic [31:0] control_r, center_r, phase_ofs_r, dividers_r;
    logic [31:0] act_freq_r, act_ofs_r, ofs_shift_r;
    logic [7:0]  act_phase_r;
    logic [31:0] acc_r;
    logic [15:0] timing_error_value_r, ser_sh_r;
    logic [4:0]  ser_cnt_r;
    logic [4:0]  ofs_cnt_r;
    logic        ofs_clk_d_r, sync_d_r, ref_d_r;

    // ======================================================================
    // decode
    wire wr         = host_wr.wr;
    wire wr_ctl     = wr && host_wr.addr == `OFS_OSC_CONTROL;
    wire wr_ctr     = wr && host_wr.addr == `OFS_CENTER_FREQ;
    wire wr_pho     = wr && host_wr.addr == `OFS_PHASE_OFFSET;
    wire wr_fstb    = wr && host_wr.addr == `OFS_FREQ_STROBE;
    wire wr_pstb    = wr && host_wr.addr == `OFS_PHASE_STROBE;
    wire wr_div     = wr && host_wr.addr == `OFS_ERROR_DIVIDERS;
    wire sync_en    = control_r[`CTL_SYNC_EN_BIT];
    wire [1:0] ofs_sel = control_r[`CTL_OFS_BITS_LSB +: 2];
    wire ofs_en     = control_r[`CTL_OFS_EN_BIT];
    wire clr_acc    = control_r[`CTL_CLEAR_BIT];
    wire load_upd   = control_r[`CTL_LOAD_ON_UPD_BIT];

    // ======================================================================
    // pin synchronisers
    logic sync_lvl, ref_lvl, ofs_clk_lvl, ofs_dat_lvl;
    pin_sync u_sync (.clk(clk), .sys_rst(sys_rst), .pin(sync_in), .level(sync_lvl));
    pin_sync u_ref (.clk(clk), .sys_rst(sys_rst), .pin(reference_clock_in),
                    .level(ref_lvl));
    pin_sync u_oclk (.clk(clk), .sys_rst(sys_rst), .pin(offset_ser_clk),
                     .level(ofs_clk_lvl));
    pin_sync u_odat (.clk(clk), .sys_rst(sys_rst), .pin(offset_ser_data),
                     .level(ofs_dat_lvl));
    wire sync_rise = sync_lvl & ~sync_d_r;
    wire ref_rise  = ref_lvl & ~ref_d_r;
    wire ofs_rise  = ofs_clk_lvl & ~ofs_clk_d_r;

    // serial offset word length: 8,16,24,32 bits
    wire [4:0] ofs_last = {ofs_sel, 3'b111};                                  // R4
    wire       ofs_done = ofs_rise && ofs_cnt_r == ofs_last;
    // left-justify the completed word into the 32-bit offset
    wire [31:0] ofs_new  = {ofs_shift_r[30:0], ofs_dat_lvl};
    wire [31:0] ofs_just = ofs_new << (5'd24 - {ofs_sel, 3'b000});           // R4

    // ======================================================================
    // accumulator step
    wire [31:0] step = act_freq_r + (ofs_en ? act_ofs_r : 32'h0000_0000);    // R5 R8
    wire [32:0] sum  = {1'b0, acc_r} + {1'b0, step};                          // R2
    wire        upd  = wr_fstb | wr_pstb;
    wire        acc_zero = clr_acc | (sync_en & sync_rise) | (load_upd & upd); // R3 R6 R7

    // ======================================================================
    // control words
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            control_r   <= `RST_WORD;
            center_r    <= `RST_WORD;
            phase_ofs_r <= `RST_WORD;
            dividers_r  <= `RST_WORD;
        end else begin
            if (wr_ctl) control_r   <= host_wr.data;
            if (wr_ctr) center_r    <= host_wr.data;
            if (wr_pho) phase_ofs_r <= {24'h00_0000, host_wr.data[7:0]};  // R9
            if (wr_div) dividers_r  <= host_wr.data;
        end
    end

    // ======================================================================
    // active values, moved on update strobes
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            act_freq_r  <= `RST_WORD;
            act_phase_r <= 8'h00;
        end else begin
            if (wr_fstb) act_freq_r  <= center_r;               // R10
            if (wr_pstb) act_phase_r <= phase_ofs_r[7:0];       // R10
        end
    end

    // ======================================================================
    // serial offset frequency, loop filter correction arrives here
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ofs_shift_r <= `RST_WORD;
            ofs_cnt_r   <= 5'h00;
            act_ofs_r   <= `RST_WORD;
            ofs_clk_d_r <= 1'b0;
        end else begin
            ofs_clk_d_r <= ofs_clk_lvl;
            if (ofs_rise) begin
                ofs_shift_r <= ofs_new;
                ofs_cnt_r   <= ofs_done ? 5'h00 : ofs_cnt_r + 5'h01;
            end
            if (ofs_done) act_ofs_r <= ofs_just;                // R19
        end
    end

    // ======================================================================
    // phase accumulator and strobe
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            acc_r     <= `RST_WORD;
            sync_d_r  <= 1'b0;
            carry_out <= 1'b0;
            tick      <= '0;
            phase_out <= 8'h00;
        end else begin
            sync_d_r   <= sync_lvl;
            acc_r      <= acc_zero ? 32'h0000_0000 : sum[31:0];
            carry_out  <= ~acc_zero & sum[32];
            tick.strobe <= ~acc_zero & sum[32];                 // R1 R18
            tick.phase  <= acc_r;                               // R1
            phase_out  <= acc_r[31:24] + act_phase_r;           // R9
        end
    end

    // ======================================================================
    // timing error counters
    logic [DW-1:0] nco_cnt;
    logic          ref_wrap;
    divide_counter #(.W(DW)) u_nco_div (
        .clk(clk), .sys_rst(sys_rst), .advance(carry_out),               // R11
        .preload(dividers_r[`DIV_NCO_LSB +: DW]),                        // R12
        .count(nco_cnt), .wrap()
    );
    divide_counter #(.W(DW)) u_ref_div (
        .clk(clk), .sys_rst(sys_rst), .advance(ref_rise),                // R11
        .preload(dividers_r[`DIV_REF_LSB +: DW]),                        // R13
        .count(), .wrap(ref_wrap)
    );

    // error sample and serial shift
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ref_d_r              <= 1'b0;
            timing_error_value_r <= 16'h0000;
            ser_sh_r             <= 16'h0000;
            ser_cnt_r            <= 5'h00;
            timing_error_ser     <= 1'b0;
            timing_error_frame   <= 1'b0;
        end else begin
            ref_d_r            <= ref_lvl;
            timing_error_frame <= ref_wrap;
            if (ref_wrap) begin
                timing_error_value_r <= 16'(nco_cnt);          // R20 R11
                ser_sh_r             <= 16'(nco_cnt);          // R14
                ser_cnt_r            <= 5'h10;
            end else if (ser_cnt_r != 5'h00) begin
                ser_sh_r  <= {ser_sh_r[14:0], 1'b0};
                ser_cnt_r <= ser_cnt_r - 5'h01;
            end
            timing_error_ser <= (ser_cnt_r != 5'h00) ? ser_sh_r[15] : 1'b0; // R14
        end
    end

    // ======================================================================
    // resampler mode figures
    logic [5:0] cyc_nxt;
    logic [2:0] int_nxt;
    always_comb begin
        case (rs_mode)
            tnco_pkg::RS_BYPASS:   begin cyc_nxt = `CYC_BYPASS;   int_nxt = 3'd1; end
            tnco_pkg::RS_POLY:     begin cyc_nxt = `CYC_POLY;     int_nxt = 3'd1; end
            tnco_pkg::RS_POLY_HB1: begin cyc_nxt = `CYC_POLY_HB1; int_nxt = 3'd2; end
            tnco_pkg::RS_POLY_HB2: begin cyc_nxt = `CYC_POLY_HB2; int_nxt = 3'd4; end
            tnco_pkg::RS_HB1:      begin cyc_nxt = `CYC_HB1;      int_nxt = 3'd2; end
            tnco_pkg::RS_HB2:      begin cyc_nxt = `CYC_HB2;      int_nxt = 3'd4; end
            default:               begin cyc_nxt = `CYC_BYPASS;   int_nxt = 3'd1; end
        endcase
    end
    wire poly_nxt = rs_mode == tnco_pkg::RS_POLY || rs_mode == tnco_pkg::RS_POLY_HB1
                 || rs_mode == tnco_pkg::RS_POLY_HB2;

    // registered mode outputs; input rate limit is 55 MHz / rs_cycles
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rs_cycles     <= `CYC_BYPASS;
            interp_factor <= 3'd1;
            poly_paced    <= 1'b0;
        end else begin
            rs_cycles     <= cyc_nxt;                           // R15 R16
            interp_factor <= int_nxt;                           // R17
            poly_paced    <= poly_nxt;                          // R18
        end
    end

    // ======================================================================
    // host read mux
    logic [31:0] rd_nxt;
    always_comb begin
        case (host_rd_addr)
            `OFS_OSC_CONTROL:    rd_nxt = control_r;
            `OFS_CENTER_FREQ:    rd_nxt = center_r;
            `OFS_PHASE_OFFSET:   rd_nxt = phase_ofs_r;
            `OFS_ERROR_DIVIDERS: rd_nxt = dividers_r;
            `OFS_ERROR_READ:     rd_nxt = {16'h0000, timing_error_value_r}; // R14
            `OFS_OFFSET_FREQ:    rd_nxt = act_ofs_r;
            default:             rd_nxt = 32'h0000_0000;
        endcase
    end
    always_ff @(posedge clk) begin
        if (sys_rst) host_rd_data <= 32'h0000_0000;
        else if (host_rd) host_rd_data <= rd_nxt;
    end
endmodule

// file: tb/timing_nco_assertions.sv
// Purpose: port checker for timing_nco
// Assumes: control bits mirrored from host writes at index 0x0B
// Notes:   bound to the design at the foot of this file
`timescale 1ns/1ps
`include "tnco_regs.svh"
module timing_nco_checker #(
    parameter int DW = 12
) (
    input wire logic                      clk,           // processing clock
    input wire logic                      sys_rst,       // sync reset
    input wire tnco_pkg::host_wr_type     host_wr,       // host write
    input wire logic                      sync_in,       // external sync pin
    input wire tnco_pkg::rs_mode_type     rs_mode,       // resampler mode
    input wire tnco_pkg::sample_tick_type tick,          // strobe and phase
    input wire logic                      carry_out,     // oscillator wrap
    input wire logic [5:0]                rs_cycles,     // clocks per input
    input wire logic [2:0]                interp_factor, // output per input
    input wire logic                      poly_paced     // strobe pacing
);
    // ==========================================================
    // helper state
    // mirror of sync enable and clear bits, seen one cycle late
    logic [1:0] ctl_r;
    logic [1:0] ctl_nxt;
    logic       poly_sel;
    assign ctl_nxt = (host_wr.wr && host_wr.addr == `OFS_OSC_CONTROL) ?
        {host_wr.data[`CTL_SYNC_EN_BIT], host_wr.data[`CTL_CLEAR_BIT]} : ctl_r;
    assign poly_sel = rs_mode inside {tnco_pkg::RS_POLY, tnco_pkg::RS_POLY_HB1,
                                      tnco_pkg::RS_POLY_HB2};
    always_ff @(posedge clk) begin
        ctl_r <= sys_rst ? 2'h0 : ctl_nxt;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    // ==========================================================
    // properties
    property p_carry;
        tick.strobe |-> carry_out ##1 tick.phase < $past(tick.phase);
    endproperty
    a_carry: assert property (p_carry) else $error("carry differs from strobe");
    property p_cyc_poly2;
        rs_mode == tnco_pkg::RS_POLY_HB2 |=> rs_cycles == 6'h17;
    endproperty
    a_cyc_poly2: assert property (p_cyc_poly2) else $error("poly hb2 cycles");
    property p_cyc_hb2;
        rs_mode == tnco_pkg::RS_HB2 |=> rs_cycles == 6'h11;
    endproperty
    a_cyc_hb2: assert property (p_cyc_hb2) else $error("hb2 cycles");
    property p_interp4;
        rs_mode inside {tnco_pkg::RS_HB2, tnco_pkg::RS_POLY_HB2} |=> interp_factor == 3'h4;
    endproperty
    a_interp4: assert property (p_interp4) else $error("interp not four");
    property p_interp2;
        rs_mode == tnco_pkg::RS_HB1 ##1 rs_mode == tnco_pkg::RS_HB1 |-> interp_factor == 3'h2;
    endproperty
    a_interp2: assert property (p_interp2) else $error("interp not two");
    property p_poly;
        1'b1 |=> poly_paced == $past(poly_sel);
    endproperty
    a_poly: assert property (p_poly) else $error("pacing wrong");
    property p_clear;
        ctl_r[0] && $past(ctl_r[0]) && $past(ctl_r[0], 2) && $past(ctl_r[0], 3)
            |-> !tick.strobe && tick.phase == 32'h0000_0000;
    endproperty
    a_clear: assert property (p_clear) else $error("accumulator not held clear");
    property p_sync;
        ctl_r[1] && $rose(sync_in) |-> ##6 tick.phase == 32'h0000_0000;
    endproperty
    a_sync: assert property (p_sync) else $error("sync did not clear");
endmodule
bind timing_nco timing_nco_checker #(.DW(DW)) u_chk (
    .clk(clk), .sys_rst(sys_rst), .host_wr(host_wr), .sync_in(sync_in),
    .rs_mode(rs_mode), .tick(tick), .carry_out(carry_out), .rs_cycles(rs_cycles),
    .interp_factor(interp_factor), .poly_paced(poly_paced)
);

// file: tb/tnco_pins_model.sv
// Purpose: far side pins: reference clock and serial offset loop filter
// Assumes: callers enter tasks just after a rising edge
// Notes:   slow edges so every level passes the synchronisers
`timescale 1ns/1ps
module tnco_pins_model (
    input wire logic clk,                // processing clock
    output logic     reference_clock_in, // reference pin
    output logic     offset_ser_clk,     // serial offset clock
    output logic     offset_ser_data     // serial offset bit
);
    // ==========================================================
    // pin drivers; serial clock stands low outside words
    initial begin
        reference_clock_in = 1'b0;
        offset_ser_clk = 1'b0;
        offset_ser_data = 1'b0;
    end
    task automatic ref_pulses(input int n, input int gap);
        repeat (n) begin
            reference_clock_in = 1'b1;
            repeat (6) @(posedge clk);
            #1 reference_clock_in = 1'b0;
            repeat (gap) @(posedge clk);
            #1;
        end
    endtask
    // loop filter correction word, msb first
    task automatic send_word(input logic [31:0] w, input int nb);
        for (int i = nb - 1; i >= 0; i--) begin
            offset_ser_data = w[i];
            repeat (5) @(posedge clk);
            #1 offset_ser_clk = 1'b1;
            repeat (5) @(posedge clk);
            #1 offset_ser_clk = 1'b0;
        end
        // released line shows the inverse so a stale sample is caught
        offset_ser_data = ~offset_ser_data;
    endtask
endmodule

// file: tb/timing_nco_test.sv
// Purpose: self-checking bench of timing_nco
// Assumes: inputs change 1 ns after the rising edge
// Notes:   expected values follow the control word layout
`timescale 1ns/1ps
`include "tnco_regs.svh"
module timing_nco_test;
    // ==========================================================
    // signals
    logic                      clk = 1'b0;
    logic                      sys_rst = 1'b1;
    tnco_pkg::host_wr_type     host_wr = '0;
    logic                      host_rd = 1'b0;
    logic [7:0]                rd_addr = 8'h00;
    logic                      sync_in = 1'b0;
    tnco_pkg::rs_mode_type     rs_mode = tnco_pkg::RS_BYPASS;
    logic                      ref_pin, ser_clk, ser_dat, te_ser, te_frame, carry, paced;
    tnco_pkg::sample_tick_type tick;
    logic [7:0]                phase_out;
    logic [5:0]                rs_cycles;
    logic [2:0]                interp;
    logic [31:0]               rd_data, rd_v;
    int                        n_mismatch = 0;
    int                        checks = 0;
    int                        n_carry = 0;
    localparam logic [7:0]  ADR [4] = '{`OFS_OSC_CONTROL, `OFS_CENTER_FREQ,
                                        `OFS_PHASE_OFFSET, `OFS_ERROR_DIVIDERS};
    localparam logic [31:0] VAL [4] = '{32'h0000_003D, 32'h1234_5678, 32'h0000_00A5,
                                        32'h0ABC_0DEF};
    localparam tnco_pkg::rs_mode_type MD [6] = '{tnco_pkg::RS_BYPASS, tnco_pkg::RS_POLY,
        tnco_pkg::RS_POLY_HB1, tnco_pkg::RS_POLY_HB2, tnco_pkg::RS_HB1, tnco_pkg::RS_HB2};
    localparam logic [5:0] CYC [6] = '{`CYC_BYPASS, `CYC_POLY, `CYC_POLY_HB1,
                                       `CYC_POLY_HB2, `CYC_HB1, `CYC_HB2};
    localparam logic [2:0] INTP [6] = '{3'h1, 3'h1, 3'h2, 3'h4, 3'h2, 3'h4};
    localparam logic [5:0] PACED = 6'h0E;
    // clock and carry tally
    always #4 clk = ~clk;
    always @(negedge clk) if (carry === 1'b1) n_carry <= n_carry + 1;
    timing_nco u_dut (.clk(clk), .sys_rst(sys_rst), .host_wr(host_wr), .host_rd(host_rd),
        .host_rd_addr(rd_addr), .offset_ser_clk(ser_clk), .offset_ser_data(ser_dat),
        .sync_in(sync_in), .reference_clock_in(ref_pin), .rs_mode(rs_mode), .tick(tick),
        .phase_out(phase_out), .carry_out(carry), .rs_cycles(rs_cycles),
        .interp_factor(interp), .poly_paced(paced), .host_rd_data(rd_data),
        .timing_error_ser(te_ser), .timing_error_frame(te_frame));
    tnco_pins_model u_pins (.clk(clk), .reference_clock_in(ref_pin),
        .offset_ser_clk(ser_clk), .offset_ser_data(ser_dat));
    // ==========================================================
    // host access and compare tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        host_wr = '{wr: 1'b1, addr: a, data: d};
        @(posedge clk);
        #1 host_wr.wr = 1'b0;
        @(posedge clk);
        #1;
    endtask
    // second edge gives margin; data stands until the next read
    task automatic rd(input logic [7:0] a);
        host_rd = 1'b1;
        rd_addr = a;
        @(posedge clk);
        #1 host_rd = 1'b0;
        @(posedge clk);
        #1 rd_v = rd_data;
    endtask
    task automatic count(input int exp);
        n_carry = 0;
        repeat (40) @(posedge clk);
        #1 chk(n_carry, exp);
    endtask
    task automatic conclude;
        $display("counts: checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // watchdog well beyond the some 1250 cycles the tests need
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        $display("ERROR t=%0t watchdog expired", $time);
        conclude();
    end
    // ==========================================================
    // test sequence
    initial begin
        logic [15:0] w;
        int k;
        repeat (8) @(posedge clk);
        #1 sys_rst = 1'b0;
        for (int i = 0; i < 4; i++) begin
            rd(ADR[i]);
            chk(rd_v, 32'h0000_0000);
            wr(ADR[i], VAL[i]);
            rd(ADR[i]);
            chk(rd_v, VAL[i]);
            wr(ADR[i], 32'h0000_0000);
        end
        rd(8'h20);
        chk(rd_v, 32'h0000_0000);
        $display("end registers");
        for (int i = 0; i < 6; i++) begin
            rs_mode = MD[i];
            repeat (2) @(posedge clk);
            #1 chk(rs_cycles, CYC[i]);
            chk(interp, INTP[i]);
            chk(paced, PACED[i]);
        end
        $display("end modes");
        wr(`OFS_CENTER_FREQ, 32'h4000_0000);
        count(0);
        wr(`OFS_FREQ_STROBE, 32'h0000_0000);
        repeat (4) @(posedge clk);
        count(10);
        $display("end frequency");
        for (int i = 0; i < 4; i++) begin
            wr(`OFS_OSC_CONTROL, 32'(i) << 3);
            u_pins.send_word(32'hC3A5_96E1 >> (24 - 8 * i), 8 * (i + 1));
            repeat (6) @(posedge clk);
            rd(`OFS_OFFSET_FREQ);
            chk(rd_v, 32'hC3A5_96E1 & ~(32'hFFFF_FFFF >> (8 * (i + 1))));
        end
        wr(`OFS_OSC_CONTROL, 32'h0000_0000);
        u_pins.send_word(32'h0000_0040, 8);
        count(10);
        wr(`OFS_OSC_CONTROL, 32'h0000_0004);
        wr(`OFS_FREQ_STROBE, 32'h0000_0000);
        repeat (4) @(posedge clk);
        count(20);
        wr(`OFS_OSC_CONTROL, 32'h0000_0001);
        wr(`OFS_FREQ_STROBE, 32'h0000_0000);
        chk(tick.phase, 32'h0000_0000);
        $display("end offset");
        wr(`OFS_OSC_CONTROL, 32'h0000_0002);
        wr(`OFS_PHASE_OFFSET, 32'h0000_0080);
        count(0);
        chk(phase_out, 8'h00);
        wr(`OFS_PHASE_STROBE, 32'h0000_0000);
        repeat (3) @(posedge clk);
        #1 chk(phase_out, 8'h80);
        wr(`OFS_OSC_CONTROL, 32'h0000_0020);
        sync_in = 1'b1;
        repeat (10) @(posedge clk);
        #1 sync_in = 1'b0;
        wr(`OFS_OSC_CONTROL, 32'h0000_0000);
        $display("end clear and sync");
        wr(`OFS_ERROR_DIVIDERS, 32'h0003_0002);
        fork
            u_pins.ref_pulses(12, 20);
        join_none
        k = 0;
        while (te_frame !== 1'b1 && k < 400) begin
            @(posedge clk);
            #1 k++;
        end
        chk(k < 400, 32'h0000_0001);
        for (int i = 0; i < 16; i++) begin
            @(posedge clk);
            #1 w = {w[14:0], te_ser};
        end
        rd(`OFS_ERROR_READ);
        chk(rd_v[15:0], w);
        chk(w <= 16'h0003, 32'h0000_0001);
        $display("end timing error");
        conclude();
    end
endmodule
